// ===== common/dmrc_regs.vh
// Mode register field layout, register select codes and timing counts
`ifndef DMRC_REGS_VH
`define DMRC_REGS_VH

// ----------------------------------------------------------------------
// Mode register select on bank address low bits
// ----------------------------------------------------------------------
`define DMRC_SEL_TIMING      2'b00
`define DMRC_SEL_IOCAL       2'b01
`define DMRC_REG_W           20

// ----------------------------------------------------------------------
// Timing/latency register fields
// ----------------------------------------------------------------------
`define DMRC_CYC_LSB         0
`define DMRC_CYC_MSB         3
`define DMRC_LAT_LSB         4
`define DMRC_LAT_MSB         7
`define DMRC_DLL_EN_BIT      8
`define DMRC_MUX_BIT         9
`define DMRC_RL_BASE         5'h05
`define DMRC_RL_MAX_CODE     4'hd

// ----------------------------------------------------------------------
// I/O and calibration register fields
// ----------------------------------------------------------------------
`define DMRC_DRV_LSB         0
`define DMRC_DRV_MSB         1
`define DMRC_ODT_LSB         2
`define DMRC_ODT_MSB         4
`define DMRC_DLL_RST_BIT     5
`define DMRC_CAL_SHORT_BIT   6
`define DMRC_CAL_START_BIT   7

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define DMRC_TIMING_RST      20'h00000
`define DMRC_IOCAL_RST       20'h00000

// ----------------------------------------------------------------------
// Address widths and calibration windows (cycles)
// ----------------------------------------------------------------------
`define DMRC_ADDR_W          20
`define DMRC_MUX_ADDR_W      11
`define DMRC_CAL_LONG_CYC    16'h0200
`define DMRC_CAL_SHORT_CYC   16'h0040

`endif

// ===== src/dmrc_cal_engine.v
// Impedance calibration sequencer with its own busy window
`timescale 1ns/100ps
module dmrc_cal_engine (
  input  wire        sys_clk,
  input  wire        sys_rst,
  input  wire        start,
  input  wire        short_mode,
  output reg         busy,
  output reg         done,
  output reg         resistor_path_en
);
`include "dmrc_regs.vh"

  reg [15:0] count;

  // ----------------------------------------------------------------------
  // Window counter
  // ----------------------------------------------------------------------
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      count            <= 16'h0000;
      busy             <= 1'b0;
      done             <= 1'b0;
      resistor_path_en <= 1'b0;
    end else begin
      done <= 1'b0;
      if (!busy && start) begin
        busy             <= 1'b1;
        resistor_path_en <= 1'b1;
        count            <= short_mode ? `DMRC_CAL_SHORT_CYC
                                       : `DMRC_CAL_LONG_CYC;
      end else if (busy) begin
        if (count == 16'h0001) begin
          busy             <= 1'b0;
          done             <= 1'b1;
          // Power saving: no current through the resistor pin when idle
          resistor_path_en <= 1'b0; // (R19)
        end
        count <= count - 16'h0001;
      end
    end
  end

endmodule // dmrc_cal_engine

// ===== src/dmrc_mode_regs.v
// Mode register bank: command capture, field decode and self-clearing bits
//
// Overview of operation
// (R1) Timing register bits 3:0 give the bank cycle time in clocks.
// (R2) Controller waits the bank cycle time between accesses to one bank.
// (R3) Controller programs cycle time 3 to 9, avoiding reserved pairs.
// (R4) Bits 7:4 set read latency 5..18; write latency is one more.
// (R5) Bit 8 enables the delay-locked loop; controller keeps it on.
// (R6) With loop off, controller sets cycle time equal to read latency.
// (R7) Controller should follow each loop enable with a loop reset.
// (R8) Bit 9 set: address latched in two halves on consecutive edges.
// (R9) Two-part mode uses 11 address inputs; single-cycle uses 20.
// (R10) Bank and command come with the first half; rest next edge.
// (R11) Controller drives upper bank bits and reserved bits low.
// (R12) Bits 1:0 pick 40 or 60 ohm drive; 40 ohm from reset.
// (R13) Bits 4:2 pick 40, 60, 120 ohm termination or none.
// (R14) Data termination off during read drive; mask and clock stay on.
// (R15) Bit 5 starts loop reset, then clears itself.
// (R16) Controller waits 512 stable clocks after loop reset before reads.
// (R17) Bit 6 picks long/short calibration; bit 7 starts, self-clears.
// (R18) Controller meets cycle time and keeps channel quiet in calibration.
// (R19) After calibration the resistor pin current path is switched off.
// (R20) Calibration may start during loop reset and lock.
// (R21) Shared-resistor calibration windows of devices must not overlap.
// (R22) Controller allows initial or operating long calibration window.
// (R23) Bank address bits 1:0 select the target mode register.
// (R24) Registers hold value until rewritten or reset.
// (R25) Controller waits the command delay after each register write.
`timescale 1ns/100ps
module dmrc_mode_regs (
  input  wire        sys_clk,
  input  wire        sys_rst,
  input  wire        chip_sel_n,
  input  wire        write_en_n,
  input  wire        refresh_n,
  input  wire [19:0] addr,
  input  wire [3:0]  bank_addr,
  input  wire        read_drive,
  output reg  [19:0] timing_latency_config,
  output reg  [19:0] io_calibration_config,
  output reg  [3:0]  bank_cycle_time,
  output reg  [4:0]  read_latency,
  output reg  [4:0]  write_latency,
  output reg         dll_enable,
  output reg         addr_mux_mode,
  output reg  [19:0] cmd_addr,
  output reg  [3:0]  cmd_bank,
  output reg  [1:0]  cmd_op,
  output reg         cmd_valid,
  output reg         drive_60_ohm,
  output reg  [2:0]  odt_select,
  output wire        dq_odt_on,
  output wire        dm_dk_odt_on,
  output reg         dll_reset_pulse,
  output wire        cal_busy,
  output wire        cal_resistor_path_en
);
`include "dmrc_regs.vh"

  // ----------------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------------
  localparam [1:0] OP_READ  = 2'h0;
  localparam [1:0] OP_WRITE = 2'h1;
  localparam [1:0] OP_REF   = 2'h2;
  localparam [1:0] OP_MRS   = 2'h3;

  localparam ST_IDLE = 1'b0;
  localparam ST_HALF = 1'b1;

  reg        state;
  reg [10:0] first_address_half;
  reg [3:0]  held_bank;
  reg [1:0]  held_op;
  reg        cal_start;
  wire       cal_done;

  wire mode_register_set_cmd = !chip_sel_n && !write_en_n && !refresh_n;
  wire read_cmd  = !chip_sel_n && write_en_n && refresh_n;
  wire write_cmd = !chip_sel_n && !write_en_n && refresh_n;
  wire ref_cmd   = !chip_sel_n && write_en_n && !refresh_n;
  wire any_cmd   = !chip_sel_n;

  function [1:0] op_code;
    input rd;
    input wr;
    input rf;
    begin
      if (rd)
        op_code = OP_READ;
      else if (wr)
        op_code = OP_WRITE;
      else if (rf)
        op_code = OP_REF;
      else
        op_code = OP_MRS;
    end
  endfunction

  // Latency code saturates at the top supported setting
  function [4:0] rl_from_code;
    input [3:0] code;
    begin
      if (code > `DMRC_RL_MAX_CODE)
        rl_from_code = `DMRC_RL_BASE + {1'b0, `DMRC_RL_MAX_CODE};
      else
        rl_from_code = `DMRC_RL_BASE + {1'b0, code};
    end
  endfunction

  // ----------------------------------------------------------------------
  // Address capture, one or two edges
  // ----------------------------------------------------------------------
  // In two-part mode the full 20-bit word is assembled from an 11-bit and
  // a 9-bit half: first carries bits 10:0, second carries bits 19:11.
  reg [19:0] full_addr;
  reg [3:0]  full_bank;
  reg [1:0]  full_op;
  reg        full_valid;

  always @* begin
    full_addr  = addr;
    full_bank  = bank_addr;
    full_op    = op_code(read_cmd, write_cmd, ref_cmd);
    full_valid = 1'b0;
    if (state == ST_HALF) begin
      full_addr  = {addr[8:0], first_address_half}; // (R9)
      full_bank  = held_bank;
      full_op    = held_op;
      full_valid = 1'b1; // (R10)
    end else if (!addr_mux_mode && any_cmd) begin
      full_valid = 1'b1; // (R9)
    end
  end

  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state              <= ST_IDLE;
      first_address_half <= 11'h000;
      held_bank          <= 4'h0;
      held_op            <= 2'h0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (addr_mux_mode && any_cmd) begin
            // Bank and command ride with the first half
            first_address_half <= addr[10:0]; // (R8)
            held_bank          <= bank_addr; // (R10)
            held_op            <= op_code(read_cmd, write_cmd, ref_cmd);
            state              <= ST_HALF; // (R8)
          end
        end
        ST_HALF: begin
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmd_addr  <= 20'h00000;
      cmd_bank  <= 4'h0;
      cmd_op    <= 2'h0;
      cmd_valid <= 1'b0;
    end else begin
      cmd_valid <= full_valid && (full_op != OP_MRS);
      if (full_valid) begin
        cmd_addr <= full_addr;
        cmd_bank <= full_bank;
        cmd_op   <= full_op;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Mode register write and self-clearing bits
  // ----------------------------------------------------------------------
  wire mrs_hit = full_valid && (full_op == OP_MRS);

  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      timing_latency_config <= `DMRC_TIMING_RST;
      io_calibration_config <= `DMRC_IOCAL_RST;
      dll_reset_pulse       <= 1'b0;
      cal_start             <= 1'b0;
    end else begin
      dll_reset_pulse <= 1'b0;
      cal_start       <= 1'b0;
      if (mrs_hit && full_bank[1:0] == `DMRC_SEL_TIMING) begin
        timing_latency_config <= full_addr; // (R23)
      end
      if (mrs_hit && full_bank[1:0] == `DMRC_SEL_IOCAL) begin
        io_calibration_config <= full_addr; // (R23)
        dll_reset_pulse <= full_addr[`DMRC_DLL_RST_BIT];
        cal_start       <= full_addr[`DMRC_CAL_START_BIT];
      end else begin
        // Loop reset bit drops once the reset has been launched
        if (dll_reset_pulse)
          io_calibration_config[`DMRC_DLL_RST_BIT] <= 1'b0; // (R15)
        // Start bit drops when the sequencer reports completion
        if (cal_done)
          io_calibration_config[`DMRC_CAL_START_BIT] <= 1'b0; // (R17)
      end
      // Otherwise every field simply holds
    end // (R24)
  end

  // ----------------------------------------------------------------------
  // Field decode to registered controls
  // ----------------------------------------------------------------------
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bank_cycle_time <= 4'h0;
      read_latency    <= `DMRC_RL_BASE;
      write_latency   <= `DMRC_RL_BASE + 5'h01;
      dll_enable      <= 1'b0;
      addr_mux_mode   <= 1'b0;
      drive_60_ohm    <= 1'b0;
      odt_select      <= 3'h0;
    end else begin
      bank_cycle_time <= timing_latency_config[`DMRC_CYC_MSB:`DMRC_CYC_LSB];
      read_latency    <= rl_from_code(
        timing_latency_config[`DMRC_LAT_MSB:`DMRC_LAT_LSB]); // (R4)
      write_latency   <= rl_from_code(
        timing_latency_config[`DMRC_LAT_MSB:`DMRC_LAT_LSB])
        + 5'h01; // (R4)
      dll_enable      <= timing_latency_config[`DMRC_DLL_EN_BIT]; // (R5)
      addr_mux_mode   <= timing_latency_config[`DMRC_MUX_BIT]; // (R8)
      // Any nonzero drive code selects 60 ohm; reset gives 40 ohm
      drive_60_ohm    <= |io_calibration_config[`DMRC_DRV_MSB:`DMRC_DRV_LSB];
      odt_select      <= io_calibration_config[`DMRC_ODT_MSB:`DMRC_ODT_LSB];
    end
  end // (R1) (R12) (R13)

  // ----------------------------------------------------------------------
  // Termination control
  // ----------------------------------------------------------------------
  // Data pins lose termination only while read data is driven out
  assign dq_odt_on    = (odt_select != 3'h0) && !read_drive; // (R14)
  assign dm_dk_odt_on = (odt_select != 3'h0); // (R14)

  // ----------------------------------------------------------------------
  // Calibration sequencer
  // ----------------------------------------------------------------------
  dmrc_cal_engine u_cal (
    .sys_clk          (sys_clk),
    .sys_rst          (sys_rst),
    .start            (cal_start),
    .short_mode       (io_calibration_config[`DMRC_CAL_SHORT_BIT]),
    .busy             (cal_busy),
    .done             (cal_done),
    .resistor_path_en (cal_resistor_path_en)
  ); // (R17) (R19)

endmodule // dmrc_mode_regs

// ===== dv/dmrc_ctrl_model.sv
// Controller model that issues commands to the mode register bank
`timescale 1ns/100ps
module dmrc_ctrl_model #(
  parameter int MRSC_CYC = 4
) (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  output logic             chip_sel_n,
  output logic             write_en_n,
  output logic             refresh_n,
  output logic [19:0]      addr,
  output logic [3:0]       bank_addr
);
  logic mux = 1'b0;
  initial begin
    chip_sel_n = 1'b1;
    write_en_n = 1'b1;
    refresh_n = 1'b1;
    addr = 20'h00000;
    bank_addr = 4'h0;
  end
  always @(posedge sys_rst) mux = 1'b0;
  // Op: 0 read, 1 write, 2 refresh, 3 mode register set
  task automatic issue(input logic [1:0] op, input logic [19:0] a,
                       input logic [3:0] b);
    @(posedge sys_clk);
    chip_sel_n <= 1'b0;
    write_en_n <= ~op[0];
    refresh_n <= ~op[1];
    bank_addr <= (op == 2'h3) ? {2'h0, b[1:0]} : b;
    addr <= mux ? {~a[19:11], a[10:0]} : a;
    if (mux) begin
      // Unused upper pins carry noise so only 11 pins may matter
      @(posedge sys_clk);
      chip_sel_n <= 1'b1;
      addr <= {~a[19:9], a[19:11]};
    end
    @(posedge sys_clk);
    chip_sel_n <= 1'b1;
    addr <= ~a;
    bank_addr <= ~b;
    if (op == 2'h3 && b[1:0] == 2'h0) mux = a[9];
    if (op == 2'h3) repeat (MRSC_CYC) @(posedge sys_clk);
  endtask
endmodule // dmrc_ctrl_model

// ===== dv/dmrc_mode_regs_asserts.sv
// Concurrent checks on the mode register bank ports
`timescale 1ns/100ps
module dmrc_mode_regs_asserts (
  input logic        sys_clk,
  input logic        sys_rst,
  input logic        chip_sel_n,
  input logic        write_en_n,
  input logic        refresh_n,
  input logic [3:0]  bank_addr,
  input logic        read_drive,
  input logic [19:0] timing_latency_config,
  input logic [19:0] io_calibration_config,
  input logic [3:0]  bank_cycle_time,
  input logic [4:0]  read_latency,
  input logic [4:0]  write_latency,
  input logic        dll_enable,
  input logic        addr_mux_mode,
  input logic [3:0]  cmd_bank,
  input logic [1:0]  cmd_op,
  input logic        cmd_valid,
  input logic        drive_60_ohm,
  input logic [2:0]  odt_select,
  input logic        dq_odt_on,
  input logic        dm_dk_odt_on,
  input logic        dll_reset_pulse,
  input logic        cal_busy,
  input logic        cal_resistor_path_en
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  logic [9:0] busy_cnt;
  logic       short_q;
  // Window length is counted, too long for a repetition
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_cnt <= 10'h000;
      short_q <= 1'b0;
    end else begin
      busy_cnt <= cal_busy ? busy_cnt + 10'h001 : 10'h000;
      short_q <= cal_busy ? short_q : io_calibration_config[6];
    end
  end
  a_cyc_fields: assert property (bank_cycle_time ==
    $past(timing_latency_config[3:0]) && dll_enable ==
    $past(timing_latency_config[8]) && addr_mux_mode ==
    $past(timing_latency_config[9])) else $error("field decode");
  a_rl_decode: assert property (read_latency ==
    (($past(timing_latency_config[7:4]) > 4'hd) ? 5'h12 :
    5'h05 + {1'b0, $past(timing_latency_config[7:4])}))
    else $error("read latency decode");
  a_wl_pair: assert property (write_latency == read_latency + 5'h01)
    else $error("write latency not read plus one");
  a_drive_odt: assert property (drive_60_ohm ==
    $past(|io_calibration_config[1:0]) && odt_select ==
    $past(io_calibration_config[4:2])) else $error("io decode");
  a_odt_gate: assert property (dq_odt_on == (odt_select != 3'h0 &&
    !read_drive) && dm_dk_odt_on == (odt_select != 3'h0))
    else $error("termination gating");
  a_dll_rst_clear: assert property ($rose(io_calibration_config[5]) |->
    dll_reset_pulse ##1 (!dll_reset_pulse && !io_calibration_config[5]))
    else $error("loop reset pulse or clear");
  a_cal_start: assert property ($rose(io_calibration_config[7]) |->
    ##[1:3] cal_busy) else $error("calibration did not start");
  a_cal_window: assert property ($fell(cal_busy) |-> busy_cnt ==
    (short_q ? 10'h040 : 10'h200)) else $error("calibration length");
  a_cal_done: assert property ($fell(cal_busy) |-> ##[0:2]
    (!io_calibration_config[7] && !cal_resistor_path_en))
    else $error("calibration end state");
  a_reg_hold: assert property (chip_sel_n ##1 chip_sel_n |=>
    $stable(timing_latency_config)) else $error("register changed");
  a_cmd_take: assert property ((!chip_sel_n && refresh_n &&
    !addr_mux_mode) |=> cmd_valid && cmd_bank == $past(bank_addr) &&
    cmd_op == {1'b0, !$past(write_en_n)}) else $error("command capture");
  cover property ($fell(cal_busy));
  cover property ($rose(dll_reset_pulse));
  cover property (cmd_valid && addr_mux_mode);
endmodule // dmrc_mode_regs_asserts
bind dmrc_mode_regs dmrc_mode_regs_asserts dmrc_mode_regs_asserts_inst (.*);

// ===== dv/dmrc_mode_regs_tb.sv
// Self-checking bench for the mode register bank
`timescale 1ns/100ps
`include "dmrc_regs.vh"
module dmrc_mode_regs_tb;
  logic [19:0] timing_latency_config, io_calibration_config, cmd_addr, addr;
  logic [19:0] pulse_cnt = 20'h00000, busy_len = 20'h00000, n0;
  logic [4:0]  read_latency, write_latency;
  logic [3:0]  bank_cycle_time, cmd_bank, bank_addr;
  logic [2:0]  odt_select;
  logic [1:0]  cmd_op;
  logic        sys_clk, sys_rst, read_drive, chip_sel_n, write_en_n, refresh_n;
  logic        dll_enable, addr_mux_mode, cmd_valid, drive_60_ohm, dq_odt_on;
  logic        dm_dk_odt_on, dll_reset_pulse, cal_busy, cal_resistor_path_en;
  int          error_cnt = 0, compares = 0, cyc_cnt = 0;
  // Rows: {register select, value, field a, field b}
  logic [30:0] rows [7] = '{
    {2'h0, 20'h00005, 4'h5, 5'h05},
    {2'h0, 20'h00103, 4'h3, 5'h05}, {2'h0, 20'h001d9, 4'h9, 5'h12},
    {2'h0, 20'h00155, 4'h5, 5'h0a}, {2'h1, 20'h00001, 4'h1, 5'h00},
    {2'h1, 20'h0000e, 4'h1, 5'h03}, {2'h1, 20'h00010, 4'h0, 5'h04}};
  dmrc_mode_regs dmrc_mode_regs_inst (.*);
  dmrc_ctrl_model dmrc_ctrl_model_inst (.*);
  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    if (error_cnt == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Channel stays quiet while the window runs
  task automatic calib(input logic sh, input logic [19:0] win);
    n0 = busy_len;
    dmrc_ctrl_model_inst.issue(2'h3, {12'h000, 1'b1, sh, 6'h10}, 4'h1);
    #1 check(cal_resistor_path_en, 1'b1);
    do begin
      @(posedge sys_clk);
      #1;
    end while (cal_busy !== 1'b0);
    check(busy_len - n0, win);
    repeat (2) @(posedge sys_clk);
    #1 check(io_calibration_config[7], 1'b0);
    check(cal_resistor_path_en, 1'b0);
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc_cnt <= cyc_cnt + 1;
    busy_len <= busy_len + {19'h00000, cal_busy};
    pulse_cnt <= pulse_cnt + {19'h00000, dll_reset_pulse};
    if (cyc_cnt == 3000) begin
      error_cnt++;
      complete_run();
    end
  end
  initial begin
    sys_rst = 1'b1;
    read_drive = 1'b0;
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    #1 check(read_latency, 5'h05);
    check(drive_60_ohm, 1'b0);
    foreach (rows[i]) begin
      dmrc_ctrl_model_inst.issue(2'h3, rows[i][28:9], {2'h0, rows[i][30:29]});
      #1;
      if (rows[i][30:29] == 2'h0) begin
        check(timing_latency_config, rows[i][28:9]);
        check(bank_cycle_time, rows[i][8:5]);
        check(read_latency, rows[i][4:0]);
        check(write_latency, rows[i][4:0] + 5'h01);
        check(dll_enable, rows[i][17]);
      end else begin
        check(io_calibration_config, rows[i][28:9]);
        check(drive_60_ohm, rows[i][5]);
        check(odt_select, rows[i][2:0]);
      end
    end
    dmrc_ctrl_model_inst.issue(2'h3, 20'h003ff, 4'h2);
    #1 check(timing_latency_config, 20'h00155);
    check(io_calibration_config, 20'h00010);
    @(posedge sys_clk) read_drive <= 1'b1;
    #1 check(dq_odt_on, 1'b0);
    check(dm_dk_odt_on, 1'b1);
    @(posedge sys_clk) read_drive <= 1'b0;
    #1 check(dq_odt_on, 1'b1);
    for (int k = 0; k < 3; k++) begin
      dmrc_ctrl_model_inst.issue(k[1:0], 20'ha5c3e, {2'h1, k[1:0]});
      #1 check(cmd_valid, 1'b1);
      check(cmd_op, k[1:0]);
      check(cmd_addr, 20'ha5c3e);
      check(cmd_bank, {2'h1, k[1:0]});
    end
    // Loop reset follows the enable; calibration overlaps its lock time
    dmrc_ctrl_model_inst.issue(2'h3, 20'h00030, 4'h1);
    #1 check(io_calibration_config[5], 1'b0);
    check(pulse_cnt, 20'h00001);
    calib(1'b0, `DMRC_CAL_LONG_CYC);
    calib(1'b1, `DMRC_CAL_SHORT_CYC);
    dmrc_ctrl_model_inst.issue(2'h3, 20'h00355, 4'h0);
    #1 check(addr_mux_mode, 1'b1);
    dmrc_ctrl_model_inst.issue(2'h1, 20'h5a5a5, 4'h7);
    #1 check(cmd_valid, 1'b1);
    check(cmd_addr, 20'h5a5a5);
    check(cmd_bank, 4'h7);
    check(cmd_op, 2'h1);
    @(posedge sys_clk) sys_rst <= 1'b1;
    @(posedge sys_clk) sys_rst <= 1'b0;
    #1 check(timing_latency_config, 20'h00000);
    check(read_latency, 5'h05);
    complete_run();
  end
endmodule // dmrc_mode_regs_tb
